/* include/tpgd_defs.vh */
// Constants for the three-phase gate drive control block
`ifndef TPGD_DEFS_VH
`define TPGD_DEFS_VH
// ============================================================
// Register offsets
`define TPGD_A_CTRL      8'h00
`define TPGD_A_DEADTIME  8'h04
`define TPGD_A_SIMUL     8'h08
`define TPGD_A_MASK      8'h0C
`define TPGD_A_STATUS0   8'h10
`define TPGD_A_CLEAR     8'h14
`define TPGD_A_CALIB     8'h18
// ============================================================
// Field positions
`define TPGD_B_BYPASS_FULL_ON_MODE    0
`define TPGD_B_DESATM    1
`define TPGD_B_ZERODT    2
`define TPGD_B_LOCK      3
`define TPGD_B_OC        0
`define TPGD_B_PHASE     1
`define TPGD_B_DESAT     2
`define TPGD_B_NOSHUT    8
`define TPGD_B_ENA       3
`define TPGD_B_SIMDONE   4
`define TPGD_B_LOCKED    5
`define TPGD_B_SIMON     6
`define TPGD_B_ARMED     8
// ============================================================
// Reset values and limits
`define TPGD_CTRL_RST    4'h2
`define TPGD_DT_RST      8'h14
`define TPGD_DT_MIN      8'h01
`define TPGD_DT_MAX      8'hFF
`define TPGD_CAL_RST     8'h05
`define TPGD_MASK_RST    9'h000
// ============================================================
// Timing
`define TPGD_CLK_NS      10
`define TPGD_STEP_NS     50
`define TPGD_FILT_NS     1000
`define TPGD_BLANK_NS    500
`endif

/* src/tpgd_top.v */
// Three-phase gate drive control: deadtime, lockout, fault logic, registers
`timescale 1ns/1ps
`include "tpgd_defs.vh"

// Functional notes
// RULE1 - Deadtime programmable in about 50 ns steps from zero to near 12 us.
// RULE2 - Host trims the deadtime time base through a calibration register.
// RULE3 - Simultaneous on mode disables the blanking delay.
// RULE4 - Simultaneous on setting accepted once per reset, later writes ignored.
// RULE5 - Full-on, desaturation and zero-deadtime modes set and then locked by host.
// RULE6 - Command leading edge turns complement off now, selected on after deadtime.
// RULE7 - Any turn-off starts the deadtime timer, blocking complement turn-on.
// RULE8 - Turn-on after deadtime elapsed happens with no added delay.
// RULE9 - High side stays off after enable until its low side was on once.
// RULE10 - Low-side current limit blanked after each input state change.
// RULE11 - Overcurrent trip changes the indication output and latches the fault.
// RULE12 - Latched overcurrent shows in status 0 and raises interrupt if unmasked.
// RULE13 - Overcurrent interrupt holds until fault gone and group A clear issued.
// RULE14 - Desat still present at blanking end after high-side on initiates fault.
// RULE15 - Initiated desat fault registers only after 1.0 us filter.
// RULE16 - Registered desat fault turns off all gates of all phases.
// RULE17 - Desat vanishing before filter end discards it and restarts filter.
// RULE18 - Valid faults recorded in status register readable by host.
// RULE19 - Host can mask interrupt sources and disable fault shutdown.
// RULE20 - Commanded deadtime limited to 1..255 time-base cycles, saturating.
// RULE21 - Phase error flag is OR over phases of high and low errors.
// RULE22 - Phase error interrupt holds until fault gone and group B clear issued.
// RULE23 - After a protective fault the lockout must be initialised again.
module tpgd_top #(
	parameter NPH = 3
) (
	// Clock and reset
	input  wire            sys_clk,
	input  wire            rst_n,
	// Register port
	input  wire [7:0]      reg_addr,
	input  wire [31:0]     reg_wdata,
	input  wire            reg_wr,
	input  wire            reg_rd,
	output reg  [31:0]     reg_rdata,
	// Enables and commands
	input  wire            enable_1,
	input  wire            enable_2,
	input  wire [NPH-1:0]  phase_high_side_cmd,
	input  wire [NPH-1:0]  phase_low_side_cmd,
	// Comparators
	input  wire            oc_comp,
	input  wire [NPH-1:0]  desat_comp,
	input  wire [NPH-1:0]  phase_switch_node,
	// Gate drives and indications
	output reg  [NPH-1:0]  phase_upper_gate,
	output reg  [NPH-1:0]  phase_lower_gate,
	output reg             overcurrent_indication,
	output wire            cur_limit_blank,
	output wire            int_out
);

	// ============================================================
	// Derived timing
	localparam FILT_CYC  = (`TPGD_FILT_NS + `TPGD_CLK_NS - 1) / `TPGD_CLK_NS;
	localparam BLANK_CYC = (`TPGD_BLANK_NS + `TPGD_CLK_NS - 1) / `TPGD_CLK_NS;
	localparam [7:0] FILT_N  = FILT_CYC[7:0];
	localparam [7:0] BLANK_N = BLANK_CYC[7:0];
	localparam [7:0] ONE8    = 8'h01;

	// Clamp a requested deadtime into the legal command range
	function [7:0] sat_dt;
		input [31:0] v;
		begin
			if (v > {24'h0000_00, `TPGD_DT_MAX})
				sat_dt = `TPGD_DT_MAX;
			else if (v < {24'h0000_00, `TPGD_DT_MIN})
				sat_dt = `TPGD_DT_MIN;
			else
				sat_dt = v[7:0];
		end
	endfunction

	// ============================================================
	// Registers
	reg [3:0]      ctrl_r;
	reg [7:0]      deadtime_r;
	reg [7:0]      calib_r;
	reg            simul_r;
	reg            simul_done_r;
	reg [8:0]      mask_r;
	reg            oc_lat_r;
	reg            phase_flag_r;
	reg            desat_flag_r;
	reg [NPH-1:0]  hs_d_r;
	reg [NPH-1:0]  ls_d_r;
	reg [NPH-1:0]  sel_hs_r;
	reg [NPH-1:0]  sel_ls_r;
	reg [NPH-1:0]  armed_r;
	reg [7:0]      dt_cnt_r [0:NPH-1];
	reg [7:0]      tb_cnt_r;
	reg [7:0]      blank_r;
	reg [NPH-1:0]  desat_init_r;
	reg [7:0]      filt_r;

	// ============================================================
	// Combinational next values
	reg [NPH-1:0]  sel_hs_nxt;
	reg [NPH-1:0]  sel_ls_nxt;
	reg [NPH-1:0]  up_nxt;
	reg [NPH-1:0]  lo_nxt;
	reg [NPH-1:0]  armed_nxt;
	reg [7:0]      dt_nxt [0:NPH-1];
	reg [NPH-1:0]  turn_off;
	reg            any_on;
	reg            any_edge;
	integer        i, j, k;

	wire           locked   = ctrl_r[`TPGD_B_LOCK];
	wire           full_on  = ctrl_r[`TPGD_B_BYPASS_FULL_ON_MODE];
	wire           zero_dt  = ctrl_r[`TPGD_B_ZERODT];
	wire           desat_md = ctrl_r[`TPGD_B_DESATM];
	wire           enabled  = enable_1 & enable_2;
	wire           no_shut  = mask_r[`TPGD_B_NOSHUT];
	// Fault state kills drive only while shutdown is allowed
	wire           shutdown = (desat_flag_r | phase_flag_r) & ~no_shut; // RULE16 RULE19
	wire           tick     = (tb_cnt_r == 8'h00);
	wire           blank_end = (blank_r == ONE8);
	wire           wr_clr   = reg_wr & (reg_addr == `TPGD_A_CLEAR);
	wire           clr_a    = wr_clr & reg_wdata[0];
	wire           clr_b    = wr_clr & reg_wdata[1];

	wire [NPH-1:0] hs_rise = phase_high_side_cmd & ~hs_d_r;
	wire [NPH-1:0] hs_fall = ~phase_high_side_cmd & hs_d_r;
	wire [NPH-1:0] ls_rise = phase_low_side_cmd & ~ls_d_r;
	wire [NPH-1:0] ls_fall = ~phase_low_side_cmd & ls_d_r;

	// Phase errors judged once the blanking window closes
	wire [NPH-1:0] ph_err = (phase_upper_gate & ~phase_switch_node) |
	                        (phase_lower_gate & phase_switch_node);
	wire           ph_any = blank_end & (|ph_err); // RULE21

	// ============================================================
	// Per-phase switching logic
	always @*
	begin
		any_on = 1'b0;
		any_edge = 1'b0;
		for (i = 0; i < NPH; i = i + 1)
		begin
			sel_hs_nxt[i] = sel_hs_r[i];
			sel_ls_nxt[i] = sel_ls_r[i];
			// Low side wins a same-cycle tie; it is the safe one
			if (hs_rise[i])
			begin
				sel_hs_nxt[i] = 1'b1;
				sel_ls_nxt[i] = 1'b0;
			end
			else if (hs_fall[i])
				sel_hs_nxt[i] = 1'b0;
			if (ls_rise[i])
			begin
				sel_ls_nxt[i] = 1'b1;
				sel_hs_nxt[i] = 1'b0;
			end
			else if (ls_fall[i])
				sel_ls_nxt[i] = 1'b0;
			any_edge = any_edge | hs_rise[i] | hs_fall[i] | ls_rise[i] | ls_fall[i];

			// Immediate turn-off of whatever is no longer selected
			up_nxt[i] = phase_upper_gate[i] & sel_hs_nxt[i]; // RULE6
			lo_nxt[i] = phase_lower_gate[i] & sel_ls_nxt[i]; // RULE6
			turn_off[i] = (phase_upper_gate[i] & ~up_nxt[i]) |
			              (phase_lower_gate[i] & ~lo_nxt[i]);

			// Deadtime timer
			if (turn_off[i])
				dt_nxt[i] = zero_dt ? 8'h00 : deadtime_r; // RULE7 RULE1
			else if (tick && (dt_cnt_r[i] != 8'h00))
				dt_nxt[i] = dt_cnt_r[i] - ONE8;
			else
				dt_nxt[i] = dt_cnt_r[i];

			// Turn-on only once the timer has run out
			if (~turn_off[i] && (dt_cnt_r[i] == 8'h00)) // RULE7 RULE8
			begin
				if (sel_hs_nxt[i] && !lo_nxt[i] && armed_r[i]) // RULE9
					up_nxt[i] = 1'b1;
				if (sel_ls_nxt[i] && !up_nxt[i])
					lo_nxt[i] = 1'b1;
			end

			// Full-on skips the decision stage, still exclusive
			if (full_on)
			begin
				up_nxt[i] = phase_high_side_cmd[i] & ~phase_low_side_cmd[i] & armed_r[i];
				lo_nxt[i] = phase_low_side_cmd[i] & ~phase_high_side_cmd[i];
			end
			// Simultaneous mode lets both sides follow their inputs
			if (simul_r)
			begin
				up_nxt[i] = phase_high_side_cmd[i] & armed_r[i];
				lo_nxt[i] = phase_low_side_cmd[i];
			end
			if (!enabled || shutdown)
			begin
				up_nxt[i] = 1'b0; // RULE16
				lo_nxt[i] = 1'b0;
			end

			// Lockout re-arms only through a low-side turn-on
			if (!enabled || shutdown)
				armed_nxt[i] = 1'b0; // RULE23
			else if (lo_nxt[i])
				armed_nxt[i] = 1'b1; // RULE9
			else
				armed_nxt[i] = armed_r[i];

			any_on = any_on | (up_nxt[i] & ~phase_upper_gate[i]) |
			         (lo_nxt[i] & ~phase_lower_gate[i]);
		end
	end

	// ============================================================
	// Gate and timer state
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hs_d_r <= {NPH{1'b0}};
			ls_d_r <= {NPH{1'b0}};
			sel_hs_r <= {NPH{1'b0}};
			sel_ls_r <= {NPH{1'b0}};
			phase_upper_gate <= {NPH{1'b0}};
			phase_lower_gate <= {NPH{1'b0}};
			armed_r <= {NPH{1'b0}};
			for (j = 0; j < NPH; j = j + 1)
				dt_cnt_r[j] <= 8'h00;
		end
		else
		begin
			hs_d_r <= phase_high_side_cmd;
			ls_d_r <= phase_low_side_cmd;
			sel_hs_r <= sel_hs_nxt;
			sel_ls_r <= sel_ls_nxt;
			phase_upper_gate <= up_nxt;
			phase_lower_gate <= lo_nxt;
			armed_r <= armed_nxt;
			for (j = 0; j < NPH; j = j + 1)
				dt_cnt_r[j] <= dt_nxt[j];
		end
	end

	// ============================================================
	// Deadtime time base, trimmed by the host
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			tb_cnt_r <= 8'h00;
		else if (tick)
			tb_cnt_r <= (calib_r == 8'h00) ? 8'h00 : calib_r - ONE8; // RULE2
		else
			tb_cnt_r <= tb_cnt_r - ONE8;
	end

	// ============================================================
	// Blanking window after switching and input changes
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			blank_r <= 8'h00;
		else if (any_on || any_edge)
			blank_r <= simul_r ? ONE8 : BLANK_N; // RULE3 RULE10
		else if (blank_r != 8'h00)
			blank_r <= blank_r - ONE8;
	end

	// Current limit stays blanked while the window is open, never in simultaneous on mode
	assign cur_limit_blank = (blank_r != 8'h00) & ~simul_r; // RULE10 RULE3

	// ============================================================
	// Desaturation detection and filter
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			desat_init_r <= {NPH{1'b0}};
			filt_r <= 8'h00;
		end
		else
		begin
			for (k = 0; k < NPH; k = k + 1)
			begin
				if (!desat_comp[k] || !phase_upper_gate[k])
					desat_init_r[k] <= 1'b0; // RULE17
				else if (blank_end && desat_md)
					desat_init_r[k] <= 1'b1; // RULE14
			end
			// Filter restarts from zero whenever nothing is pending
			if (desat_init_r == {NPH{1'b0}})
				filt_r <= 8'h00; // RULE17
			else if (filt_r != FILT_N)
				filt_r <= filt_r + ONE8; // RULE15
		end
	end

	// ============================================================
	// Fault flags; a new event beats a clear in the same cycle
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			overcurrent_indication <= 1'b0;
			oc_lat_r <= 1'b0;
			phase_flag_r <= 1'b0;
			desat_flag_r <= 1'b0;
		end
		else
		begin
			overcurrent_indication <= oc_comp; // RULE11
			if (oc_comp)
				oc_lat_r <= 1'b1; // RULE11
			else if (clr_a)
				oc_lat_r <= 1'b0; // RULE13
			if (ph_any)
				phase_flag_r <= 1'b1; // RULE21
			else if (clr_b && (ph_err == {NPH{1'b0}}))
				phase_flag_r <= 1'b0; // RULE22
			if (filt_r == FILT_N)
				desat_flag_r <= 1'b1; // RULE15
			else if (clr_b && (desat_comp == {NPH{1'b0}}))
				desat_flag_r <= 1'b0; // RULE22
		end
	end

	assign int_out = (oc_lat_r & mask_r[`TPGD_B_OC]) | // RULE12 RULE19
	                 (phase_flag_r & mask_r[`TPGD_B_PHASE]) |
	                 (desat_flag_r & mask_r[`TPGD_B_DESAT]);

	// ============================================================
	// Register writes
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r <= `TPGD_CTRL_RST;
			deadtime_r <= `TPGD_DT_RST;
			calib_r <= `TPGD_CAL_RST;
			simul_r <= 1'b0;
			simul_done_r <= 1'b0;
			mask_r <= `TPGD_MASK_RST;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`TPGD_A_CTRL:
				begin
					// Lock bit freezes modes until the next reset
					if (!locked)
						ctrl_r <= reg_wdata[3:0]; // RULE5
				end
				`TPGD_A_DEADTIME:
					deadtime_r <= sat_dt(reg_wdata); // RULE20 RULE1
				`TPGD_A_CALIB:
					calib_r <= reg_wdata[7:0]; // RULE2
				`TPGD_A_SIMUL:
				begin
					if (!simul_done_r)
					begin
						simul_r <= reg_wdata[0]; // RULE4
						simul_done_r <= 1'b1; // RULE4
					end
				end
				`TPGD_A_MASK:
					mask_r <= reg_wdata[8:0]; // RULE19
				default:
					mask_r <= mask_r;
			endcase
		end
	end

	// ============================================================
	// Register reads, one cycle latency
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`TPGD_A_CTRL:
					reg_rdata <= {28'h000_0000, ctrl_r};
				`TPGD_A_DEADTIME:
					reg_rdata <= {24'h0000_00, deadtime_r};
				`TPGD_A_CALIB:
					reg_rdata <= {24'h0000_00, calib_r};
				`TPGD_A_SIMUL:
					reg_rdata <= {31'h0000_0000, simul_r};
				`TPGD_A_MASK:
					reg_rdata <= {23'h00_0000, mask_r};
				`TPGD_A_STATUS0:
					reg_rdata <= {21'h00_0000, armed_r, 1'b0, simul_r, locked, // RULE18
					              simul_done_r, enabled, desat_flag_r, phase_flag_r, oc_lat_r}; // RULE12
				default:
					reg_rdata <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata <= 32'h0000_0000;
	end

endmodule // tpgd_top

/* verification/tb_top.sv */
// Self-checking bench for the gate drive control block
`timescale 1ns/1ps
`include "tpgd_defs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t got %h want %h", $time, a, b); end end
module tb_top;
	reg         sys_clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg         enable_1 = 1'b0;
	reg         enable_2 = 1'b0;
	reg         oc_comp = 1'b0;
	reg         desat_force = 1'b0;
	reg         node_hold = 1'b0;
	reg [7:0]   reg_addr = 8'h00;
	reg [31:0]  reg_wdata = 32'h0000_0000;
	reg [31:0]  rd;
	reg [2:0]   hs = 3'h0;
	reg [2:0]   ls = 3'h0;
	wire [31:0] reg_rdata;
	wire [2:0]  upper;
	wire [2:0]  lower;
	wire [2:0]  node;
	wire [2:0]  desat;
	wire        oc_ind;
	wire        int_out;
	integer     errors = 0;
	integer     samples_checked = 0;
	integer     cyc = 0;
	integer     n;
	// ============================================================
	// Design and power stage
	tpgd_top #(.NPH(3)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.enable_1(enable_1), .enable_2(enable_2), .phase_high_side_cmd(hs), .phase_low_side_cmd(ls),
		.oc_comp(oc_comp), .desat_comp(desat), .phase_switch_node(node), .phase_upper_gate(upper),
		.phase_lower_gate(lower), .overcurrent_indication(oc_ind), .cur_limit_blank(), .int_out(int_out));
	tpgd_stage_model stage_u (.sys_clk(sys_clk), .phase_upper_gate(upper), .phase_lower_gate(lower),
		.desat_force(desat_force), .node_hold(node_hold), .phase_switch_node(node), .desat_comp(desat));
	// ============================================================
	// Clock, timeout, tasks
	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			tally_and_finish;
		end
	end
	task tally_and_finish;
	begin
		$display("compared %0d mismatched %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task wr(input [7:0] a, input [31:0] d);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	end
	endtask
	task rdr(input [7:0] a);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	end
	endtask
	task tick(input integer k);
	begin
		repeat (k) @(posedge sys_clk);
		#1;
	end
	endtask
	// Bounded wait for a phase 0 gate to come on, cycles left in n
	task wait_on(input sel_lower);
	begin
		n = 0;
		while (((sel_lower ? lower[0] : upper[0]) !== 1'b1) && n < 2000)
		begin
			@(posedge sys_clk);
			#1 n = n + 1;
		end
	end
	endtask
	// ============================================================
	// Tests
	initial
	begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdr(`TPGD_A_CTRL); `CHK(rd, 32'h0000_0002)
		rdr(`TPGD_A_DEADTIME); `CHK(rd, 32'h0000_0014)
		rdr(8'hFC); `CHK(rd, 32'h0000_0000)
		wr(`TPGD_A_DEADTIME, 32'h0000_0000);
		rdr(`TPGD_A_DEADTIME); `CHK(rd, 32'h0000_0001)
		wr(`TPGD_A_DEADTIME, 32'h0000_01FF);
		rdr(`TPGD_A_DEADTIME); `CHK(rd, 32'h0000_00FF)
		wr(`TPGD_A_SIMUL, 32'h0000_0000);
		wr(`TPGD_A_SIMUL, 32'h0000_0001);
		wr(`TPGD_A_CTRL, 32'h0000_000A);
		wr(`TPGD_A_CTRL, 32'h0000_0003);
		rdr(`TPGD_A_CTRL); `CHK(rd[3:0], 4'hA)
		rdr(`TPGD_A_STATUS0); `CHK(rd[6:4], 3'h3)
		$display("registers done");
		// Lockout until the low side has been on once
		@(posedge sys_clk) enable_1 <= 1'b1;
		@(posedge sys_clk) enable_2 <= 1'b1;
		@(posedge sys_clk) hs <= 3'h1;
		tick(40); `CHK(upper, 3'h0)
		@(posedge sys_clk) hs <= 3'h0;
		@(posedge sys_clk) ls <= 3'h1;
		wait_on(1'b1);
		wr(`TPGD_A_CALIB, 32'h0000_0002);
		wr(`TPGD_A_DEADTIME, 32'h0000_0003);
		@(posedge sys_clk) hs <= 3'h1;
		wait_on(1'b0); `CHK(n >= 6 && n <= 12, 1'b1)
		@(posedge sys_clk) hs <= 3'h0;
		ls <= 3'h0;
		tick(40);
		@(posedge sys_clk) ls <= 3'h1;
		wait_on(1'b1); `CHK(n <= 2, 1'b1)
		$display("deadtime done");
		// Overcurrent latch, interrupt and clear
		wr(`TPGD_A_MASK, 32'h0000_0001);
		@(posedge sys_clk) oc_comp <= 1'b1;
		tick(3); `CHK({oc_ind, int_out}, 2'h3)
		wr(`TPGD_A_CLEAR, 32'h0000_0001); `CHK(int_out, 1'b1)
		@(posedge sys_clk) oc_comp <= 1'b0;
		rdr(`TPGD_A_STATUS0); `CHK(rd[0], 1'b1)
		wr(`TPGD_A_CLEAR, 32'h0000_0001); `CHK(int_out, 1'b0)
		$display("overcurrent done");
		// Short desaturation is filtered out, long one shuts down
		@(posedge sys_clk) desat_force <= 1'b1;
		@(posedge sys_clk) hs <= 3'h1;
		wait_on(1'b0);
		tick(110);
		@(posedge sys_clk) desat_force <= 1'b0;
		rdr(`TPGD_A_STATUS0); `CHK(rd[2], 1'b0)
		@(posedge sys_clk) hs <= 3'h0;
		@(posedge sys_clk) desat_force <= 1'b1;
		@(posedge sys_clk) hs <= 3'h1;
		wait_on(1'b0);
		tick(300);
		rdr(`TPGD_A_STATUS0); `CHK(rd[2], 1'b1)
		`CHK({upper, lower}, 6'h00)
		@(posedge sys_clk) desat_force <= 1'b0;
		wr(`TPGD_A_CLEAR, 32'h0000_0002);
		rdr(`TPGD_A_STATUS0); `CHK(rd[2], 1'b0)
		@(posedge sys_clk) hs <= 3'h0;
		@(posedge sys_clk) hs <= 3'h1;
		tick(100); `CHK(upper, 3'h0)
		$display("desaturation done");
		// Stuck switch node gives a phase error and shuts down
		@(posedge sys_clk) hs <= 3'h0;
		ls <= 3'h0;
		@(posedge sys_clk) ls <= 3'h1;
		wait_on(1'b1);
		wr(`TPGD_A_MASK, 32'h0000_0002);
		@(posedge sys_clk) node_hold <= 1'b1;
		@(posedge sys_clk) hs <= 3'h1;
		wait_on(1'b0);
		tick(80);
		`CHK({int_out, upper[0]}, 2'h2)
		rdr(`TPGD_A_STATUS0);
		`CHK(rd[1], 1'b1)
		wr(`TPGD_A_CLEAR, 32'h0000_0001);
		`CHK(int_out, 1'b1)
		@(posedge sys_clk) node_hold <= 1'b0;
		wr(`TPGD_A_CLEAR, 32'h0000_0002);
		`CHK(int_out, 1'b0)
		$display("phase error done");
		// Second reset frees the locks; full-on skips the deadtime
		@(posedge sys_clk) hs <= 3'h0;
		ls <= 3'h0;
		@(posedge sys_clk) rst_n <= 1'b0;
		tick(2);
		@(posedge sys_clk) rst_n <= 1'b1;
		rdr(`TPGD_A_STATUS0);
		`CHK(rd[5:4], 2'h0)
		wr(`TPGD_A_CTRL, 32'h0000_0001);
		@(posedge sys_clk) ls <= 3'h1;
		wait_on(1'b1);
		@(posedge sys_clk) ls <= 3'h0;
		tick(3);
		@(posedge sys_clk) hs <= 3'h1;
		wait_on(1'b0);
		`CHK(n, 1)
		$display("full-on done");
		tally_and_finish;
	end
endmodule // tb_top

/* verification/tpgd_monitor.sv */
// Assertion checker for the gate drive control block
`timescale 1ns/1ps
module tpgd_monitor #(
	parameter NPH = 3
) (
	// Clock and reset
	input wire           sys_clk,
	input wire           rst_n,
	// Register port
	input wire           reg_wr,
	input wire           reg_rd,
	input wire [31:0]    reg_rdata,
	// Commands and comparators
	input wire           enable_1,
	input wire           enable_2,
	input wire [NPH-1:0] phase_low_side_cmd,
	input wire           oc_comp,
	// Outputs
	input wire [NPH-1:0] phase_upper_gate,
	input wire [NPH-1:0] phase_lower_gate,
	input wire           overcurrent_indication,
	input wire           cur_limit_blank,
	input wire           int_out
);
	// ============================================================
	// Properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	no_overlap_a: assert property ((phase_upper_gate & phase_lower_gate) == '0)
		else $error("both gates of a phase on");
	dead_gap_a: assert property ($fell(phase_lower_gate[0]) |-> !phase_upper_gate[0] ##1 !phase_upper_gate[0])
		else $error("upper gate on inside deadtime");
	off_now_a: assert property ($rose(phase_low_side_cmd[0]) |=> !phase_upper_gate[0])
		else $error("upper gate not dropped on low side edge");
	disable_off_a: assert property (!(enable_1 && enable_2) |=> (phase_upper_gate | phase_lower_gate) == '0)
		else $error("gate on while disabled");
	oc_follow_a: assert property (overcurrent_indication == $past(oc_comp))
		else $error("overcurrent indication lags wrongly");
	blank_edge_a: assert property ($changed(phase_low_side_cmd) |=> cur_limit_blank [*8])
		else $error("no blanking after input change");
	int_hold_a: assert property ($fell(int_out) |-> $past(reg_wr))
		else $error("interrupt dropped without host write");
	read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside answer cycle");
	cover property ($rose(int_out));
	cover property ($rose(phase_upper_gate[0]));
	cover property ($fell(phase_lower_gate[0]));
endmodule // tpgd_monitor

bind tpgd_top tpgd_monitor #(.NPH(NPH)) mon_u (.*);

/* verification/tpgd_stage_model.sv */
// Power stage model: switch nodes and desaturation comparators
`timescale 1ns/1ps
module tpgd_stage_model (
	// Clock
	input wire        sys_clk,
	// Gate drives and fault injection
	input wire [2:0]  phase_upper_gate,
	input wire [2:0]  phase_lower_gate,
	input wire        desat_force,
	input wire        node_hold,
	// Comparator outputs
	output reg [2:0]  phase_switch_node = 3'h0,
	output wire [2:0] desat_comp
);
	// ============================================================
	// Node floats with both gates off, so it wanders each cycle
	// Hold pins the node low to fake a stuck phase
	always @(posedge sys_clk)
		phase_switch_node <= node_hold ? 3'h0 : (phase_upper_gate | (~phase_lower_gate & ~phase_switch_node));
	// Only a conducting upper switch can show desaturation
	assign desat_comp = phase_upper_gate & {3{desat_force}};
endmodule // tpgd_stage_model
